// *** hdl/smc_pkg.sv ***
package smc_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [15:0] IDX_CLK_DIV  = 16'h3000;
   localparam logic [15:0] IDX_CLK_CTL  = 16'h3001;
   localparam logic [15:0] IDX_CFG_ONE  = 16'h3002;
   localparam logic [15:0] IDX_CFG_TWO  = 16'h3003;
   localparam logic [15:0] IDX_CMD_ONE  = 16'h3004;
   localparam logic [15:0] IDX_CMD_TWO  = 16'h3005;
   localparam logic [15:0] IDX_STAT_ONE = 16'h3006;
   localparam logic [15:0] IDX_STAT_TWO = 16'h3007;
   localparam logic [15:0] IDX_DAT_ONE  = 16'h3008;
   localparam logic [15:0] IDX_DAT_TWO  = 16'h3009;
   localparam logic [15:0] IDX_IRQ_STAT = 16'h300a;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h300b;
   localparam int          ADDR_W       = 18;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CC_EN      = 15;  // clock control: port enable
   localparam int CF2_LOOP   = 15;  // config two: loopback
   localparam int CF2_DLY_LO = 0;   // config two: cs-to-data delay [1:0]
   localparam int CF1_POL    = 0;   // config one: per slave 4 bits: pol, pha, cs_pol
   localparam int CF1_PHA    = 1;
   localparam int CF1_CSP    = 2;
   localparam int CMD1_IE    = 15;  // command one: char interrupt enable
   localparam int CMD2_LEN   = 3;   // command two: length-1 at [7:3]
   localparam int CMD2_CS    = 12;  // command two: slave at [13:12]
   localparam int ST_BUSY    = 0;
   localparam int ST_CHAR    = 1;
   localparam int CNT_W      = 12;
   localparam int LEN_W      = 5;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam logic [3:0]  IRQ_ALL   = 4'hf;

   typedef enum logic [3:0] {
      SMC_IDLE  = 4'b0001,
      SMC_DELAY = 4'b0010,
      SMC_SHIFT = 4'b0100,
      SMC_DONE  = 4'b1000
   } smc_state_t;
endpackage : smc_pkg

// *** hdl/smc_spi_master.sv ***
// How it works
// - Master only; this block always drives serial clock and selects.
// - Each serial clock cycle shifts one bit out and one bit in.
// - Character length is one to 32 bits.
// - Four select outputs, one per slave, share clock and data.
// - A frame is one to 4096 characters back to back.
// - Optional interrupt after each completed character.
// - One to four serial clock cycles from select to first bit.
// - Serial clock comes from a programmable system clock divider.
// - Idle polarity, phase and select level are programmable.
// - Loopback feeds transmit output back into receive input.
// - One clock out, select outputs, one receive in, one transmit out.
// - Modes 0..3 are polarity/phase 00, 01, 10, 11.
// - Mode 0 launches after falling edge and samples on rising edge.
`timescale 1ns/1ns
`default_nettype none
module smc_spi_master
   import smc_pkg::*;
(
   input  wire logic                 sys_clk,      // 20 MHz system clock
   input  wire logic                 arst_n,       // async reset, active low
   input  wire logic                 wb_cyc_i,     // bus cycle
   input  wire logic                 wb_stb_i,     // strobe
   input  wire logic                 wb_we_i,      // write
   input  wire logic [smc_pkg::ADDR_W-1:0] wb_adr_i, // byte address
   input  wire logic [3:0]           wb_sel_i,     // byte lanes
   input  wire logic [31:0]          wb_dat_i,     // write data
   output logic      [31:0]          wb_dat_o,     // read data
   output logic                      wb_ack_o,     // acknowledge
   output logic                      irq,          // level interrupt
   output logic                      serial_clk,   // serial clock
   output logic      [3:0]           slave_select_lines, // chip selects
   output logic                      serial_tx,    // transmit data
   input  wire logic                 serial_rx     // receive data
);
   import smc_pkg::*;
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] clk_div, clk_ctl, cfg_one, cfg_two, cmd_one, cmd_two;
   logic [31:0] rx_data;
   logic [3:0]  irq_stat, irq_mask;
   logic        char_ready;
   smc_state_t  state;
   logic [15:0] div_cnt;
   logic        phase_hi;
   logic [LEN_W-1:0] bit_cnt;
   logic [CNT_W-1:0] chr_cnt;
   logic [1:0]  dly_cnt;
   logic [31:0] tx_sh, rx_sh;
   logic [1:0]  cur_cs;
   logic        sclk_int;

   wire         acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [15:0]  idx      = wb_adr_i[ADDR_W-1:2];
   wire         wr       = acc & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
   wire         wr_cmd2  = wr & (idx == IDX_CMD_TWO);
   wire         rd_dat   = acc & ~wb_we_i & (idx == IDX_DAT_ONE);
   wire         start    = wr_cmd2 & (state == SMC_IDLE) & clk_ctl[CC_EN];
   wire [3:0]   slv_cfg  = cfg_one[{cur_cs, 2'b00} +: 4];
   wire         cpol     = slv_cfg[CF1_POL];
   wire         cpha     = slv_cfg[CF1_PHA];
   wire [LEN_W-1:0] len_m1 = cmd_two[CMD2_LEN +: LEN_W];
   // Divider: tick every clk_div+1 system clocks is one half bit
   wire         tick     = (div_cnt == 16'h0000);
   wire         busy     = (state != SMC_IDLE);
   wire         rx_bit   = cfg_two[CF2_LOOP] ? serial_tx : serial_rx;
   wire         last_bit = (bit_cnt == len_m1);
   wire         last_chr = (chr_cnt == cmd_one[CNT_W-1:0]);
   wire         char_end = (state == SMC_SHIFT) & tick & phase_hi & last_bit;
   wire [15:0]  stat_one = {14'h0000, char_ready, busy};
   wire [31:0]  rx_mask  = {32{1'b1}} >> (5'd31 - len_m1);

   // ------------------------------------------------------------
   // Bus slave: one registered ack the cycle after the request, unmapped reads zero
   // ------------------------------------------------------------
   logic [15:0] rd_mux;
   always_comb begin
      case (idx)
         IDX_CLK_DIV:  rd_mux = clk_div;
         IDX_CLK_CTL:  rd_mux = clk_ctl;
         IDX_CFG_ONE:  rd_mux = cfg_one;
         IDX_CFG_TWO:  rd_mux = cfg_two;
         IDX_CMD_ONE:  rd_mux = cmd_one;
         IDX_CMD_TWO:  rd_mux = cmd_two;
         IDX_STAT_ONE: rd_mux = stat_one;
         IDX_STAT_TWO: rd_mux = {12'h000, 2'b00, cur_cs};
         IDX_DAT_ONE:  rd_mux = rx_data[15:0];
         IDX_DAT_TWO:  rd_mux = rx_data[31:16];
         IDX_IRQ_STAT: rd_mux = {12'h000, irq_stat};
         IDX_IRQ_MASK: rd_mux = {12'h000, irq_mask};
         default:      rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= acc;
         wb_dat_o <= acc ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_div <= DIV_RESET;
         clk_ctl <= 16'h0000;
         cfg_one <= 16'h0000;
         cfg_two <= 16'h0000;
         cmd_one <= 16'h0000;
         cmd_two <= 16'h0000;
         tx_sh   <= 32'h0000_0000;
         irq_mask <= 4'h0;
      end else begin
         if (wr & (idx == IDX_CLK_DIV)) clk_div <= wb_dat_i[15:0];
         if (wr & (idx == IDX_CLK_CTL)) clk_ctl <= wb_dat_i[15:0];
         if (wr & (idx == IDX_CFG_ONE) & ~busy) cfg_one <= wb_dat_i[15:0];
         if (wr & (idx == IDX_CFG_TWO) & ~busy) cfg_two <= wb_dat_i[15:0];
         if (wr & (idx == IDX_CMD_ONE) & ~busy) cmd_one <= wb_dat_i[15:0];
         if (start) cmd_two <= wb_dat_i[15:0];
         if (wr & (idx == IDX_DAT_ONE)) tx_sh[15:0] <= wb_dat_i[15:0];
         if (wr & (idx == IDX_DAT_TWO)) tx_sh[31:16] <= wb_dat_i[15:0];
         if (wr & (idx == IDX_IRQ_MASK)) irq_mask <= wb_dat_i[3:0];
         // Shift out MSB of the character, which sits at bit len_m1
         if ((state == SMC_SHIFT) & tick & phase_hi) tx_sh <= {tx_sh[30:0], 1'b0};
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= SMC_IDLE;
         div_cnt  <= 16'h0000;
         phase_hi <= 1'b0;
         bit_cnt  <= '0;
         chr_cnt  <= '0;
         dly_cnt  <= 2'b00;
         cur_cs   <= 2'b00;
         rx_sh    <= 32'h0000_0000;
         rx_data  <= 32'h0000_0000;
         char_ready <= 1'b0;
      end else begin
         div_cnt <= (tick | ~busy) ? clk_div : div_cnt - 16'h0001;
         if (rd_dat) char_ready <= 1'b0;
         case (state)
            SMC_IDLE: begin
               phase_hi <= 1'b0;
               if (start) begin
                  cur_cs  <= wb_dat_i[CMD2_CS +: 2];
                  dly_cnt <= cfg_two[CF2_DLY_LO +: 2];
                  chr_cnt <= '0;
                  bit_cnt <= '0;
                  state   <= SMC_DELAY;
               end
            end
            SMC_DELAY: begin
               if (tick) begin
                  phase_hi <= ~phase_hi;
                  if (phase_hi) begin
                     if (dly_cnt == 2'b00) state <= SMC_SHIFT;
                     else dly_cnt <= dly_cnt - 2'b01;
                  end
               end
               if (tick & phase_hi & (dly_cnt == 2'b00)) phase_hi <= 1'b0;
            end
            SMC_SHIFT: begin
               if (tick) begin
                  phase_hi <= ~phase_hi;
                  // First half samples, second half launches the next bit
                  if (!phase_hi) rx_sh <= {rx_sh[30:0], rx_bit};
                  else begin
                     bit_cnt <= last_bit ? '0 : bit_cnt + 1'b1;
                     if (last_bit) begin
                        rx_data    <= rx_sh & rx_mask;
                        char_ready <= 1'b1;
                        if (last_chr) state <= SMC_DONE;
                        else chr_cnt <= chr_cnt + 1'b1;
                     end
                  end
               end
            end
            SMC_DONE: begin
               if (tick) state <= SMC_IDLE;
            end
            default: state <= SMC_IDLE;
         endcase
      end
   end

   // Next character data must be written after the previous one ends,
   // since there is no transmit buffer behind the shift register.
   assign sclk_int = (state == SMC_SHIFT) & (phase_hi ^ cpha);

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_cs
         // Only the addressed slave is driven to its active level
         assign slave_select_lines[g] = cfg_one[4*g+CF1_CSP] ^
               ~(busy & (cur_cs == 2'(g)));
      end
   endgenerate
   assign serial_clk = cpol ^ sclk_int;
   assign serial_tx  = (state == SMC_SHIFT) & tx_sh[len_m1];

   // ------------------------------------------------------------
   // Interrupts: bit 0 char done, bit 1 frame done
   // ------------------------------------------------------------
   wire ev_char  = char_end & cmd_one[CMD1_IE];
   wire ev_frame = char_end & last_chr;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) irq_stat <= 4'h0;
      else irq_stat <= (irq_stat & ~((wr & (idx == IDX_IRQ_STAT)) ? wb_dat_i[3:0] : 4'h0))
                       | {2'b00, ev_frame, ev_char};
   end
   assign irq = |(irq_stat & irq_mask & IRQ_ALL);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_start; start; endsequence
   sequence s_delay; state == SMC_DELAY; endsequence
   ack_one_cycle_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single cycle");
   start_to_delay_a: assert property (s_start |=> s_delay)
      else $error("frame did not start");
   clk_idle_a: assert property (!busy |-> serial_clk == cpol)
      else $error("serial clock not idle");
   cs_active_a: assert property (busy |-> slave_select_lines[cur_cs] == cfg_one[{cur_cs,2'b00}+CF1_CSP])
      else $error("select not active in frame");
   cs_idle_a: assert property (!busy |-> slave_select_lines == ~{cfg_one[14],cfg_one[10],cfg_one[6],cfg_one[2]})
      else $error("select active while idle");
   tx_quiet_a: assert property (state != SMC_SHIFT |-> !serial_tx)
      else $error("transmit outside shift");
   char_flag_a: assert property (char_end |=> char_ready)
      else $error("char ready not set");
   irq_level_a: assert property (|(irq_stat & irq_mask) |-> irq)
      else $error("irq missing");
   loop_a: assert property (cfg_two[CF2_LOOP] && state == SMC_SHIFT && tick && !phase_hi
                            |=> rx_sh[0] == $past(serial_tx))
      else $error("loopback bit lost");
   busy_done_a: assert property (state == SMC_DONE && tick |=> !busy)
      else $error("frame did not end");
endmodule : smc_spi_master
`default_nettype wire

// *** test/smc_slave_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module smc_slave_model (
   input  wire logic        serial_clk, // serial clock from the master
   input  wire logic        sel,        // this slave is addressed
   input  wire logic        pol,        // idle clock level
   input  wire logic        pha,        // 1: sample on trailing edge
   input  wire logic        serial_tx,  // master to slave data
   input  wire logic [31:0] reply,      // word sent back, right aligned
   input  wire logic [5:0]  len,        // character length
   output logic             serial_rx,  // slave to master data
   output logic [31:0]      got,        // last bits received
   output int               n_bits      // bits sampled in this frame
);
   int k;
   time t_sel;
   // Reply repeats each character, msb first
   function automatic logic nxt(input int i);
      return reply[len - 1 - (i % len)];
   endfunction : nxt
   initial serial_rx = 1'b0;
   always @(posedge sel) begin
      t_sel = $time;
      got = 32'h0;
      n_bits = 0;
      k = 0;
      if (!pha) begin
         serial_rx = nxt(0);
         k = 1;
      end
   end
   // Released line shows the inverse so a stale bit cannot pass
   always @(negedge sel) serial_rx = ~serial_rx;
   always @(serial_clk) begin
      // Select and idle level of a newly addressed slave move together
      if (sel && $time != t_sel) begin
         if ((serial_clk != pol) == pha) begin
            serial_rx = nxt(k);
            k++;
         end else begin
            got = {got[30:0], serial_tx};
            n_bits++;
         end
      end
   end
endmodule : smc_slave_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import smc_pkg::*;
   typedef struct {int n; logic [31:0] w; bit chk;} smc_note_t;
   logic        sys_clk, arst_n, cyc, stb, we, run, pol, pha, sclk_q;
   logic        wb_ack_o, irq, serial_clk, serial_tx, serial_rx;
   logic [17:0] adr;
   logic [31:0] dat_w, rep, got, wb_dat_o;
   logic [3:0]  csp, exp_cs, slave_select_lines;
   logic [5:0]  len;
   logic [1:0]  cur;
   int          num_errors, checks_done, cycles, n_bits, gap, half, seed, k, ln;
   bit          gap_on, one_chr, sel_q;
   logic [15:0] rq[$];
   smc_note_t   fq[$];
   smc_note_t   note;
   wire logic   sel = run && (slave_select_lines[cur] === csp[cur]);

   smc_spi_master dut (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq(irq), .serial_clk(serial_clk),
      .slave_select_lines(slave_select_lines), .serial_tx(serial_tx), .serial_rx(serial_rx));
   smc_slave_model peer (.serial_clk(serial_clk), .sel(sel), .pol(pol), .pha(pha),
      .serial_tx(serial_tx), .reply(rep), .len(len), .serial_rx(serial_rx), .got(got),
      .n_bits(n_bits));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task check_v(input logic [31:0] a, input logic [31:0] b);
      checks_done++;
      if (a !== b) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, a, b);
      end
   endtask : check_v
   task check_rd(input logic [15:0] e);
      check_v(wb_dat_o, {16'h0, e});
   endtask : check_rd
   task end_sim;
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------
   // Bus cycles: request held until ack is seen at an edge
   // ------------------------------------------------------------
   task automatic wb_go(input logic [15:0] idx, input logic w, input logic [15:0] d);
      int i;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat_w <= {16'h0, d};
      i = 0;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1 && i < 100) begin
         @(posedge sys_clk);
         i++;
      end
      if (i >= 100) num_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
   endtask : wb_go
   task automatic wb_wr(input logic [15:0] idx, input logic [15:0] d);
      wb_go(idx, 1'b1, d);
   endtask : wb_wr
   task automatic wb_rd(input logic [15:0] idx, input logic [15:0] e);
      rq.push_back(e);
      wb_go(idx, 1'b0, 16'h0);
   endtask : wb_rd

   // Watcher: read data, select lines, half-bit spacing, frame results
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 60000) begin
         num_errors++;
         end_sim();
      end
      if (wb_ack_o === 1'b1 && we === 1'b0 && rq.size() > 0) check_rd(rq.pop_front());
      if (sel) check_v(32'(slave_select_lines), 32'(exp_cs));
      if (sel && sel_q && serial_clk !== sclk_q) begin
         if (gap_on && one_chr) check_v(gap, half);
         gap = 0;
         gap_on = 1'b1;
      end
      if (!sel) gap_on = 1'b0;
      gap++;
      sclk_q = serial_clk;
      sel_q = sel;
   end
   always @(negedge sel) begin
      if (fq.size() > 0) begin
         note = fq.pop_front();
         check_v(n_bits, note.n);
         if (note.chk) check_v(got, note.w);
      end
   end

   task automatic frame(input int m, c, l, d, nch, ie, lp);
      logic [31:0] tx, msk;
      logic [15:0] cf;
      tx = $random(seed);
      rep = $random(seed);
      csp = 4'($random(seed));
      msk = (l == 32) ? 32'hffffffff : (32'h1 << l) - 32'h1;
      pol = m[1];
      pha = m[0];
      cur = 2'(c);
      len = 6'(l);
      one_chr = (nch == 1);
      cf = 16'h0;
      for (int i = 0; i < 4; i++) cf[4*i+2] = csp[i];
      cf[4*c +: 2] = {pha, pol};
      exp_cs = ~csp;
      exp_cs[c] = csp[c];
      wb_wr(IDX_CFG_ONE, cf);
      wb_wr(IDX_CFG_TWO, {lp[0], 13'h0, 2'(d)});
      wb_wr(IDX_CMD_ONE, {ie[0], 3'h0, 12'(nch - 1)});
      wb_wr(IDX_DAT_ONE, tx[15:0]);
      wb_wr(IDX_DAT_TWO, tx[31:16]);
      fq.push_back('{nch * l, tx & msk, nch == 1});
      run = 1'b1;
      wb_wr(IDX_CMD_TWO, {2'h0, 2'(c), 4'h0, 5'(l - 1), 3'h0});
      wb_rd(IDX_STAT_ONE, 16'h0001);
      for (int i = 0; i < 20000 && sel !== 1'b0; i++) @(posedge sys_clk);
      run = 1'b0;
      repeat (4) @(posedge sys_clk);
      check_v(32'(serial_clk), 32'(pol));
      wb_rd(IDX_STAT_ONE, 16'h0002);
      wb_rd(IDX_IRQ_STAT, {14'h0, 1'b1, ie[0]});
      wb_wr(IDX_IRQ_MASK, 16'h0);
      check_v(32'(irq), 32'h0);
      wb_wr(IDX_IRQ_MASK, 16'h3);
      check_v(32'(irq), 32'h1);
      wb_wr(IDX_IRQ_STAT, 16'h3);
      check_v(32'(irq), 32'h0);
      wb_wr(IDX_IRQ_MASK, 16'h0);
      msk = (lp != 0 ? tx : rep) & msk;
      wb_rd(IDX_DAT_ONE, msk[15:0]);
      wb_rd(IDX_DAT_TWO, msk[31:16]);
      wb_rd(IDX_STAT_ONE, 16'h0000);
   endtask : frame

   initial begin
      seed = 32'h0b8f6ab0;
      arst_n = 1'b0;
      {cyc, stb, we, run, pol, pha} = 6'h0;
      adr = 18'h0;
      dat_w = 32'h0;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      wb_rd(IDX_CLK_DIV, DIV_RESET);
      wb_rd(16'h300c, 16'h0000);
      wb_wr(IDX_STAT_ONE, 16'hffff);
      wb_wr(IDX_CMD_TWO, 16'h0038);
      wb_rd(IDX_STAT_ONE, 16'h0000);
      wb_wr(IDX_CLK_CTL, 16'h8000);
      half = 2 + int'($unsigned($random(seed)) % 4);
      wb_wr(IDX_CLK_DIV, 16'(half - 1));
      wb_rd(IDX_CLK_DIV, 16'(half - 1));
      for (k = 0; k < 4; k++) begin
         ln = (k == 0) ? 1 : (k == 3) ? 32 : 1 + int'($unsigned($random(seed)) % 32);
         frame(k, 3 - k, ln, k, 1, k % 2, 0);
      end
      frame(0, 2, 8, 3, 3, 1, 0);
      frame(1, 1, 17, 0, 1, 0, 1);
      check_v(32'(fq.size()), 32'h0);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
